/* design/pcg_pkg.sv */
// What this block does, and what its software must do
// RQ1: internal 1 MHz oscillator is default reference
// RQ2: external reference is oscillator over divider plus one
// RQ3: VCO is twice reference times multiplier plus one
// RQ4: locked output is VCO over post divider plus one
// RQ5: unlocked output is VCO divided by four
// RQ6: bus is half output, or oscillator when deselected
// RQ7: software sets both loop range fields correctly
// RQ8: phase detector pulses follow reference/feedback phase
// RQ9: read-only lock bit with lock/unlock hysteresis
// RQ10: lock toggle raises interrupt when enabled
// RQ11: software trusts VCO only after lock reads set
// RQ12: lock decided by comparing feedback and reference frequency
// RQ13: software clears lock interrupt enable before stop
// RQ14: software clears both enables before full stop
// RQ15: oscillator-up flag set after oscillator starts successfully
// RQ16: single spikes dropped, bursts clear up and lock
// RQ17: spike filtering works with either bus source
// RQ18: with synth bus source disturbances always flagged
// RQ19: reset gives engaged-internal mode, 64/16/8 MHz setup
// RQ20: watchdog and periodic timer run from internal oscillator
// RQ21: software prefers low multiplier, high reference
// RQ22: oscillator register write clears lock and up
// RQ23: software writes VCO/oscillator ratio halved into filter
// RQ24: key 0x26 unprotects, other writes protect
// RQ25: lock counts feedback edges over reference window
package pcg_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_SYNTH   = 8'h00;
    localparam logic [7:0] OFS_REFERENCE_DIVIDER  = 8'h04;
    localparam logic [7:0] OFS_OUTPUT_DIVIDER = 8'h08;
    localparam logic [7:0] OFS_CLKSEL  = 8'h0c;
    localparam logic [7:0] OFS_OSC     = 8'h10;
    localparam logic [7:0] OFS_CONFIG_WRITE_PROTECT    = 8'h14;
    localparam logic [7:0] OFS_IRQEN   = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;

    // field positions
    localparam int RANGE_LSB    = 6;
    localparam int OSC_EN_BIT   = 7;
    localparam int LOCK_IRQ_ENABLE_BIT   = 0;
    localparam int OSC_STATUS_IRQ_ENABLE_BIT    = 1;
    localparam int ST_LOCK_BIT  = 0;
    localparam int ST_UP_BIT    = 1;
    localparam int ST_LFLG_BIT  = 2;
    localparam int ST_OFLG_BIT  = 3;
    localparam int ST_EXTR_BIT  = 4;

    // engaged-internal reset setup: 1 MHz x 64 = 64 MHz, post 0x03
    localparam logic [5:0] RST_SYNTH_MULTIPLIER   = 6'h1f;
    localparam logic [1:0] RST_VCORANGE = 2'h1;
    localparam logic [3:0] RST_REFERENCE_DIVIDER   = 4'h0;
    localparam logic [1:0] RST_REFRANGE = 2'h0;
    localparam logic [4:0] RST_OUTPUT_DIVIDER  = 5'h03;
    localparam logic       RST_BUS_FROM_SYNTH_SELECT   = 1'b1;

    localparam logic [7:0] CONFIG_WRITE_PROTECT_KEY          = 8'h26;
    localparam logic [7:0] UNLOCKED_RATIO    = 8'h04;
    localparam logic [7:0] LOCK_WINDOW       = 8'h10;
    localparam logic [7:0] LOCK_TOL          = 8'h01;
    localparam logic [7:0] UNLOCK_TOL        = 8'h02;
    localparam logic [1:0] SPIKE_BURST       = 2'h2;
    localparam logic [4:0] OSC_UP_EDGES      = 5'h10;
endpackage : pcg_pkg

/* design/pcg_divider.sv */
`timescale 1ns/1ps
// counts input ticks, emits one tick per ratio ticks and a divided level
module pcg_divider #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         inTick,
    input  wire logic         inLevel,
    input  wire logic [W-1:0] ratio,
    output logic              outTick,
    output logic              outLevel
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } pcg_div_state_t;

    pcg_div_state_t st_reg;
    pcg_div_state_t st_next;
    logic           wrap;

    // ratio of zero is treated as one so the counter never runs away
    always_comb
    begin
        st_next = st_reg;
        wrap    = (st_reg.cnt >= ratio - W'(1)) || (ratio == '0);
        if (inTick)
        begin
            st_next.cnt = wrap ? '0 : st_reg.cnt + W'(1);
        end
        outTick  = inTick && wrap;
        outLevel = (ratio <= W'(1)) ? inLevel : (st_reg.cnt < (ratio >> 1));
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule : pcg_divider

/* design/pcg_clock_gen.sv */
`timescale 1ns/1ps
module pcg_clock_gen (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        internalOscPin,
    input  wire logic        extOscPin,
    input  wire logic        vcoPin,
    output logic             synthRefClk,
    output logic             feedbackClk,
    output logic             synthOutClk,
    output logic             busClk,
    output logic             wdogRtiClk,
    output logic             pdUp,
    output logic             pdDown,
    output logic             lockIrq,
    output logic             oscIrq,
    output logic             extOscEnable,
    output logic [1:0]       refRange,
    output logic [1:0]       vcoRange
);
    // sync bit order: 0 internal oscillator, 1 external oscillator, 2 vco
    typedef struct packed {
        logic [2:0]  syncA;
        logic [2:0]  syncB;
        logic [2:0]  syncC;
        logic        aValid;
        logic        aWrite;
        logic [7:0]  aOfs;
        logic        ready;
        logic [31:0] rdata;
        logic [5:0]  synth_multiplier;
        logic [1:0]  vcoRng;
        logic [3:0]  reference_divider;
        logic [1:0]  refRng;
        logic [4:0]  output_divider;
        logic        bus_from_synth_select;
        logic        oscEn;
        logic [4:0]  filtRatio;
        logic        config_write_protect;
        logic        lock_irq_enable;
        logic        osc_status_irq_enable;
        logic        lock;
        logic        oscUp;
        logic        lockFlag;
        logic        oscFlag;
        logic [7:0]  winCnt;
        logic [7:0]  fbCnt;
        logic [6:0]  spikeCnt;
        logic [1:0]  badRun;
        logic [4:0]  upCnt;
        logic        spike_filter_ratio;
        logic        pdUp;
        logic        pdDown;
        logic        synth_reference_clock;
        logic        feedback_clock;
        logic        synthClk;
        logic        busClk;
        logic        wdogClk;
        logic        lockIrq;
        logic        oscIrq;
    } pcg_state_t;

    pcg_state_t s_reg;
    pcg_state_t s_next;

    logic [2:0] rise;
    logic [2:0] fall;
    logic       wrPhase;
    logic       cfgOk;
    logic       oscWrite;
    logic       protWrite;
    logic       spike;
    logic       burst;
    logic       oscGoodTick;
    logic       refTick;
    logic       refLevel;
    logic       refDivTick;
    logic       refDivLevel;
    logic       fbTick;
    logic       fbLevel;
    logic       postTick;
    logic       postLevel;
    logic [7:0] refRatio;
    logic [7:0] fbRatio;
    logic [7:0] postRatio;
    logic [7:0] fbTotal;
    logic [7:0] diff;

    // field plus one, widened to the divider width
    function automatic logic [7:0] plusOne(input logic [7:0] v);
        plusOne = v + 8'h01;
    endfunction : plusOne

    function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
        absDiff = (a > b) ? (a - b) : (b - a);
    endfunction : absDiff

    // ratios feeding the three dividers
    always_comb
    begin
        refRatio  = plusOne({4'h0, s_reg.reference_divider}); // RQ2
        fbRatio   = plusOne({2'h0, s_reg.synth_multiplier}) << 1; // RQ3
        postRatio = s_reg.lock ? plusOne({3'h0, s_reg.output_divider}) : pcg_pkg::UNLOCKED_RATIO; // RQ4 RQ5
    end

    // edges come only from the second and third stages
    assign rise = s_reg.syncB & ~s_reg.syncC;
    assign fall = ~s_reg.syncB & s_reg.syncC;

    pcg_divider #(.W(8)) uRefDiv (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inTick   (oscGoodTick),
        .inLevel  (s_reg.spike_filter_ratio),
        .ratio    (refRatio),
        .outTick  (refDivTick),
        .outLevel (refDivLevel)
    );

    pcg_divider #(.W(8)) uFbDiv (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inTick   (rise[2]),
        .inLevel  (s_reg.syncB[2]),
        .ratio    (fbRatio),
        .outTick  (fbTick),
        .outLevel (fbLevel)
    );

    pcg_divider #(.W(8)) uPostDiv (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inTick   (rise[2]),
        .inLevel  (s_reg.syncB[2]),
        .ratio    (postRatio),
        .outTick  (postTick),
        .outLevel (postLevel)
    );

    // spike filter qualifies oscillator edges against vco edge count
    // a suppressed edge does not restart the count, so one spike costs nothing
    always_comb
    begin
        spike       = rise[1] && (s_reg.filtRatio != '0)
                      && (s_reg.spikeCnt < {2'h0, s_reg.filtRatio}); // RQ16 RQ17
        burst       = spike && s_reg.oscEn
                      && ((s_reg.badRun + 2'h1) >= pcg_pkg::SPIKE_BURST); // RQ16 RQ18
        oscGoodTick = rise[1] && !spike;
        refTick     = s_reg.oscEn ? refDivTick : rise[0]; // RQ1 RQ2
        refLevel    = s_reg.oscEn ? refDivLevel : s_reg.syncB[0]; // RQ1 RQ2
        fbTotal     = s_reg.fbCnt + {7'h0, fbTick};
        diff        = absDiff(fbTotal, pcg_pkg::LOCK_WINDOW);
    end

    // write data phase decode
    always_comb
    begin
        wrPhase   = s_reg.aValid && s_reg.aWrite;
        cfgOk     = !s_reg.config_write_protect; // RQ24
        oscWrite  = wrPhase && (s_reg.aOfs == pcg_pkg::OFS_OSC) && cfgOk && s_reg.bus_from_synth_select;
        protWrite = wrPhase && (s_reg.aOfs == pcg_pkg::OFS_CONFIG_WRITE_PROTECT);
    end

    always_comb
    begin
        s_next       = s_reg;
        s_next.syncA = {vcoPin, extOscPin, internalOscPin};
        s_next.syncB = s_reg.syncA;
        s_next.syncC = s_reg.syncB;
        s_next.ready = 1'b1;

        // ahb address phase: zero wait states, read data prepared here
        s_next.aValid = hsel && htrans[1] && hready;
        s_next.aWrite = hwrite;
        s_next.aOfs   = haddr[7:0];
        s_next.rdata  = '0;
        if (hsel && htrans[1] && hready && !hwrite && (haddr[31:8] == '0))
        begin
            if (haddr[7:0] == pcg_pkg::OFS_SYNTH)
                s_next.rdata = {24'h0, s_reg.vcoRng, s_reg.synth_multiplier};
            else if (haddr[7:0] == pcg_pkg::OFS_REFERENCE_DIVIDER)
                s_next.rdata = {24'h0, s_reg.refRng, 2'h0, s_reg.reference_divider};
            else if (haddr[7:0] == pcg_pkg::OFS_OUTPUT_DIVIDER)
                s_next.rdata = {27'h0, s_reg.output_divider};
            else if (haddr[7:0] == pcg_pkg::OFS_CLKSEL)
                s_next.rdata = {31'h0, s_reg.bus_from_synth_select};
            else if (haddr[7:0] == pcg_pkg::OFS_OSC)
                s_next.rdata = {24'h0, s_reg.oscEn, 2'h0, s_reg.filtRatio};
            else if (haddr[7:0] == pcg_pkg::OFS_CONFIG_WRITE_PROTECT)
                s_next.rdata = {31'h0, s_reg.config_write_protect};
            else if (haddr[7:0] == pcg_pkg::OFS_IRQEN)
                s_next.rdata = {30'h0, s_reg.osc_status_irq_enable, s_reg.lock_irq_enable};
            else if (haddr[7:0] == pcg_pkg::OFS_STATUS)
                s_next.rdata = {27'h0, s_reg.oscEn, s_reg.oscFlag, s_reg.lockFlag,
                                s_reg.oscUp, s_reg.lock}; // RQ9
        end

        // ahb data phase: register writes, protection checked first
        if (wrPhase && cfgOk)
        begin
            if (s_reg.aOfs == pcg_pkg::OFS_SYNTH)
            begin
                s_next.synth_multiplier = hwdata[5:0];
                s_next.vcoRng = hwdata[pcg_pkg::RANGE_LSB +: 2];
            end
            else if (s_reg.aOfs == pcg_pkg::OFS_REFERENCE_DIVIDER)
            begin
                s_next.reference_divider = hwdata[3:0];
                s_next.refRng = hwdata[pcg_pkg::RANGE_LSB +: 2];
            end
            else if (s_reg.aOfs == pcg_pkg::OFS_OUTPUT_DIVIDER)
                s_next.output_divider = hwdata[4:0];
            else if (s_reg.aOfs == pcg_pkg::OFS_CLKSEL)
                s_next.bus_from_synth_select = hwdata[0]; // RQ6
        end
        if (oscWrite)
        begin
            s_next.oscEn     = hwdata[pcg_pkg::OSC_EN_BIT]; // RQ15
            s_next.filtRatio = hwdata[4:0];
        end
        if (protWrite)
            s_next.config_write_protect = (hwdata[7:0] != pcg_pkg::CONFIG_WRITE_PROTECT_KEY); // RQ24
        if (wrPhase && (s_reg.aOfs == pcg_pkg::OFS_IRQEN))
        begin
            s_next.lock_irq_enable = hwdata[pcg_pkg::LOCK_IRQ_ENABLE_BIT];
            s_next.osc_status_irq_enable  = hwdata[pcg_pkg::OSC_STATUS_IRQ_ENABLE_BIT];
        end
        // flags clear by writing one; hardware set below wins
        if (wrPhase && (s_reg.aOfs == pcg_pkg::OFS_STATUS))
        begin
            if (hwdata[pcg_pkg::ST_LFLG_BIT])
                s_next.lockFlag = 1'b0;
            if (hwdata[pcg_pkg::ST_OFLG_BIT])
                s_next.oscFlag = 1'b0;
        end

        // oscillator qualification count and filtered level
        if (rise[2] && (s_reg.spikeCnt != '1))
            s_next.spikeCnt = s_reg.spikeCnt + 7'h01;
        if (fall[1])
            s_next.spike_filter_ratio = 1'b0;
        if (oscGoodTick)
        begin
            s_next.spike_filter_ratio  = 1'b1;
            s_next.spikeCnt = '0;
            s_next.badRun   = '0;
            if (s_reg.upCnt != pcg_pkg::OSC_UP_EDGES)
                s_next.upCnt = s_reg.upCnt + 5'h01;
            else if (s_reg.oscEn)
                s_next.oscUp = 1'b1; // RQ15
        end
        else if (spike)
            s_next.badRun = s_reg.badRun + 2'h1;

        // lock detector: feedback edges over a window of reference edges
        if (fbTick && (s_reg.fbCnt != '1))
            s_next.fbCnt = fbTotal; // RQ25
        if (refTick)
        begin
            s_next.winCnt = s_reg.winCnt + 8'h01;
            if (s_reg.winCnt == pcg_pkg::LOCK_WINDOW - 8'h01)
            begin
                s_next.winCnt = '0;
                s_next.fbCnt  = '0;
                if (!s_reg.lock && (diff <= pcg_pkg::LOCK_TOL))
                    s_next.lock = 1'b1; // RQ9 RQ12
                else if (s_reg.lock && (diff > pcg_pkg::UNLOCK_TOL))
                    s_next.lock = 1'b0; // RQ9
            end
        end

        // disturbance and configuration change drop the status
        if (!s_reg.oscEn)
        begin
            s_next.oscUp  = 1'b0;
            s_next.upCnt  = '0;
            s_next.badRun = '0;
        end
        if (burst || oscWrite)
        begin
            s_next.oscUp  = 1'b0; // RQ16 RQ22
            s_next.lock   = 1'b0; // RQ16 RQ22
            // restart the window so a half-old count cannot relock at once
            s_next.winCnt = '0;
            s_next.fbCnt  = '0;
            s_next.upCnt  = '0;
            s_next.badRun = '0;
        end

        // a toggle of lock or oscUp sets its sticky flag
        if (s_next.lock != s_reg.lock)
            s_next.lockFlag = 1'b1; // RQ10
        if (s_next.oscUp != s_reg.oscUp)
            s_next.oscFlag = 1'b1;
        s_next.lockIrq = s_reg.lockFlag && s_reg.lock_irq_enable; // RQ10
        s_next.oscIrq  = s_reg.oscFlag && s_reg.osc_status_irq_enable;

        // simple phase-frequency detector, both set cancels
        if ((refTick || s_reg.pdUp) && (fbTick || s_reg.pdDown))
        begin
            s_next.pdUp   = 1'b0; // RQ8
            s_next.pdDown = 1'b0;
        end
        else
        begin
            s_next.pdUp   = refTick || s_reg.pdUp; // RQ8
            s_next.pdDown = fbTick || s_reg.pdDown;
        end

        // clock outputs, all retimed on clk_sys
        s_next.synth_reference_clock   = refLevel;
        s_next.feedback_clock    = fbLevel;
        s_next.synthClk = postLevel;
        if (postTick)
            s_next.busClk = !s_reg.busClk;
        if (!s_reg.bus_from_synth_select)
            s_next.busClk = s_reg.spike_filter_ratio; // RQ6
        s_next.wdogClk = s_reg.syncB[0]; // RQ20
    end

    // the only register stage outside the three dividers; engaged-internal setup on reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg        <= '0;
            s_reg.synth_multiplier <= pcg_pkg::RST_SYNTH_MULTIPLIER; // RQ19
            s_reg.vcoRng <= pcg_pkg::RST_VCORANGE;
            s_reg.reference_divider <= pcg_pkg::RST_REFERENCE_DIVIDER;
            s_reg.refRng <= pcg_pkg::RST_REFRANGE;
            s_reg.output_divider <= pcg_pkg::RST_OUTPUT_DIVIDER; // RQ19
            s_reg.bus_from_synth_select <= pcg_pkg::RST_BUS_FROM_SYNTH_SELECT; // RQ19
        end
        else
            s_reg <= s_next;
    end

    assign hreadyout    = s_reg.ready;
    assign hresp        = 1'b0 & s_reg.ready;
    assign hrdata       = s_reg.rdata;
    assign synthRefClk  = s_reg.synth_reference_clock;
    assign feedbackClk  = s_reg.feedback_clock;
    assign synthOutClk  = s_reg.synthClk;
    assign busClk       = s_reg.busClk;
    assign wdogRtiClk   = s_reg.wdogClk;
    assign pdUp         = s_reg.pdUp;
    assign pdDown       = s_reg.pdDown;
    assign lockIrq      = s_reg.lockIrq;
    assign oscIrq       = s_reg.oscIrq;
    assign extOscEnable = s_reg.oscEn;
    assign refRange     = s_reg.refRng;
    assign vcoRange     = s_reg.vcoRng;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_osc_wr;
        oscWrite;
    endsequence

    sequence s_status_clear;
        !s_reg.lock && !s_reg.oscUp;
    endsequence

    a_ref_internal: assert property (!s_reg.oscEn |-> refLevel == s_reg.syncB[0]) // RQ1
        else $error("internal reference not used");
    a_unlocked_div4: assert property (!s_reg.lock |-> postRatio == 8'h04) // RQ5
        else $error("unlocked post ratio not four");
    a_osc_wr_clears: assert property (s_osc_wr |=> s_status_clear) // RQ22
        else $error("oscillator write kept status");
    a_burst_clears: assert property (burst |=> s_status_clear) // RQ16
        else $error("burst kept status");
    a_config_write_protect_key: assert property (protWrite && hwdata[7:0] == 8'h26 |=> !s_reg.config_write_protect) // RQ24
        else $error("key did not unprotect");
    a_config_write_protect_other: assert property (protWrite && hwdata[7:0] != 8'h26 |=> s_reg.config_write_protect) // RQ24
        else $error("other write did not protect");
    a_lock_irq: assert property (s_reg.lock_irq_enable && $changed(s_reg.lock) |=> lockIrq) // RQ10
        else $error("lock toggle raised no interrupt");
    a_pd_up: assert property (refTick && !fbTick && !s_reg.pdDown |=> pdUp) // RQ8
        else $error("reference lead gave no up pulse");
    a_bus_osc: assert property (!s_reg.bus_from_synth_select |=> busClk == $past(s_reg.spike_filter_ratio)) // RQ6
        else $error("bus not from oscillator");
    a_lock_hyst: assert property (refTick && s_reg.lock && diff <= 8'h02
                                  && !burst && !oscWrite |=> s_reg.lock) // RQ9
        else $error("lock lost inside unlock tolerance");
endmodule : pcg_clock_gen

/* bench/pcg_clock_gen_tb.sv */
`timescale 1ns/1ps
// one compare, counted; a mismatch is reported at once
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module pcg_clock_gen_tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        internalOscPin = 1'b0;
    logic        extOscPin = 1'b0;
    logic        vcoPin = 1'b0;
    logic        hreadyout, hresp, synthRefClk, feedbackClk, synthOutClk, busClk;
    logic        wdogRtiClk, pdUp, pdDown, lockIrq, oscIrq, extOscEnable;
    logic [31:0] hrdata;
    logic [1:0]  refRange, vcoRange;
    logic [7:0]  mon;
    logic [7:0]  monPrev = 8'h0;
    int          errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          intHalf = 40;
    int          extHalf = 0;
    int          vcoHalf = 5;
    int          cnt [8] = '{default: 0};
    int          base [8];
    int          got [8];

    pcg_clock_gen uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .internalOscPin(internalOscPin), .extOscPin(extOscPin), .vcoPin(vcoPin),
        .synthRefClk(synthRefClk), .feedbackClk(feedbackClk), .synthOutClk(synthOutClk),
        .busClk(busClk), .wdogRtiClk(wdogRtiClk), .pdUp(pdUp), .pdDown(pdDown),
        .lockIrq(lockIrq), .oscIrq(oscIrq), .extOscEnable(extOscEnable),
        .refRange(refRange), .vcoRange(vcoRange));

    always #5 clk_sys = ~clk_sys;

    // pin clocks far below the sampling rate, a half period of 0 holds the pin still
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (intHalf > 0 && cyc % intHalf == 0) internalOscPin <= ~internalOscPin;
        if (extHalf > 0 && cyc % extHalf == 0) extOscPin <= ~extOscPin;
        if (vcoHalf > 0 && cyc % vcoHalf == 0) vcoPin <= ~vcoPin;
    end

    // rising edges of pins and clock outputs, compared as ratios over a window
    assign mon = {wdogRtiClk, busClk, synthOutClk, feedbackClk, synthRefClk,
                  vcoPin, extOscPin, internalOscPin};
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 8; i++)
            if (mon[i] === 1'b1 && monPrev[i] === 1'b0) cnt[i]++;
        monPrev <= mon;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic fail_hang();
        errors++;
        $display("BAD t=%0t wait ran out", $time);
        give_verdict();
    endtask : fail_hang

    // samples ready and data just before the edge that takes them
    task automatic wait_ready(output logic [31:0] d);
        logic rdy;
        for (int i = 0; i < 50; i++)
        begin
            @(negedge clk_sys);
            d = hrdata;
            rdy = hreadyout;
            @(posedge clk_sys);
            if (rdy === 1'b1) return;
        end
        fail_hang();
    endtask : wait_ready

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [31:0] d;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(a, 1'b1, wd, d);
    endtask : wr

    task automatic poll(input int b);
        logic [31:0] s;
        for (int i = 0; i < 500; i++)
        begin
            xfer(pcg_pkg::OFS_STATUS, 1'b0, 32'h0, s);
            if (s[b] === 1'b1) return;
            repeat (10) @(posedge clk_sys);
        end
        fail_hang();
    endtask : poll

    task automatic measure(input int n);
        base = cnt;
        repeat (n) @(posedge clk_sys);
        foreach (got[i]) got[i] = cnt[i] - base[i];
    endtask : measure

    // edge counts drift by a couple at the window ends
    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction : near

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        fail_hang();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0]  rng;
        int          p;
        int          r;
        logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h40};
        logic [31:0] rv [6] = '{32'h5f, 32'h0, 32'h3, 32'h1, 32'h0, 32'h0};
        void'($urandom(32'h330d3b29));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset setup, then an unmapped place that reads zero
        foreach (ra[i])
        begin
            xfer(ra[i], 1'b0, 32'h0, d);
            `CHK(d, rv[i])
        end
        // default multiplier keeps the loop unlocked: output is vco over four
        measure(1200);
        `CHK(near(got[5], got[2] / 4), 1'b1)
        `CHK(near(got[6], got[5] / 2), 1'b1)
        `CHK(near(got[3], got[0]), 1'b1)
        `CHK(near(got[7], got[0]), 1'b1)
        // any non-key value protects; the key opens again
        wr(pcg_pkg::OFS_CONFIG_WRITE_PROTECT, 32'h1);
        wr(pcg_pkg::OFS_SYNTH, 32'h3);
        xfer(pcg_pkg::OFS_SYNTH, 1'b0, 32'h0, d);
        `CHK(d, 32'h5f)
        `CHK(hresp, 1'b0)
        wr(pcg_pkg::OFS_CONFIG_WRITE_PROTECT, 32'h26);
        rng = 2'h0;
        // lowest multiplier that still locks to the slow reference
        wr(pcg_pkg::OFS_SYNTH, {24'h0, rng, 6'h03});
        wr(pcg_pkg::OFS_IRQEN, 32'h3);
        xfer(pcg_pkg::OFS_SYNTH, 1'b0, 32'h0, d);
        `CHK(d, {24'h0, rng, 6'h03})
        `CHK(vcoRange, rng)
        // multiplier 3 makes feedback match the 80-cycle reference
        poll(pcg_pkg::ST_LOCK_BIT);
        repeat (3) @(posedge clk_sys);
        `CHK(lockIrq, 1'b1)
        `CHK(oscIrq, 1'b0)
        p = $urandom % 4;
        wr(pcg_pkg::OFS_OUTPUT_DIVIDER, 32'(p));
        measure(1600);
        `CHK(near(got[5], got[2] / (p + 1)), 1'b1)
        `CHK(near(got[4], got[2] / 8), 1'b1)
        `CHK(near(got[6], got[5] / 2), 1'b1)
        wr(pcg_pkg::OFS_STATUS, 32'h4);
        repeat (3) @(posedge clk_sys);
        `CHK(lockIrq, 1'b0)
        // oscillator on: the write drops lock, which raises the flag again
        r = $urandom % 4;
        wr(pcg_pkg::OFS_REFERENCE_DIVIDER, 32'h40 | 32'(r));
        extHalf = 10;
        wr(pcg_pkg::OFS_OSC, 32'h80);
        xfer(pcg_pkg::OFS_STATUS, 1'b0, 32'h0, d);
        `CHK(d[1:0], 2'b00)
        `CHK(lockIrq, 1'b1)
        `CHK(extOscEnable, 1'b1)
        `CHK(refRange, 2'h1)
        poll(pcg_pkg::ST_UP_BIT);
        xfer(pcg_pkg::OFS_STATUS, 1'b0, 32'h0, d);
        `CHK(d[4], 1'b1)
        `CHK(oscIrq, 1'b1)
        measure(1600);
        `CHK(near(got[3], got[1] / (r + 1)), 1'b1)
        // bus straight from the oscillator; oscillator register then refuses writes
        wr(pcg_pkg::OFS_CLKSEL, 32'h0);
        measure(800);
        `CHK(near(got[6], got[1]), 1'b1)
        wr(pcg_pkg::OFS_OSC, 32'h0);
        @(negedge clk_sys);
        `CHK(extOscEnable, 1'b1)
        // back on the synth bus, filter on, then a burst of fast edges
        wr(pcg_pkg::OFS_CLKSEL, 32'h1);
        wr(pcg_pkg::OFS_OSC, 32'h81);
        poll(pcg_pkg::ST_UP_BIT);
        extHalf = 1;
        repeat (40) @(posedge clk_sys);
        xfer(pcg_pkg::OFS_STATUS, 1'b0, 32'h0, d);
        `CHK(d[1], 1'b0)
        extHalf = 10;
        wr(pcg_pkg::OFS_IRQEN, 32'h0);
        repeat (3) @(posedge clk_sys);
        `CHK({oscIrq, lockIrq}, 2'b00)
        give_verdict();
    end
endmodule : pcg_clock_gen_tb
